// >>> rtl/smb_burst_order.sv
`timescale 1ns/1ps
module smb_burst_order
  import smb_pkg::*;
#(
  parameter int COL_BITS = 8
) (
  input  wire logic [COL_BITS-1:0] startCol,
  input  wire logic [COL_BITS-1:0] beatCount,
  input  wire logic [2:0]          lenCode,
  input  wire logic                interleave,
  output logic      [COL_BITS-1:0] col,
  output logic                     lastBeat
);

  logic [COL_BITS-1:0] mask;
  logic [COL_BITS-1:0] seqOff;
  logic [COL_BITS-1:0] intOff;
  logic                fullPage;

  // block size from burst length, reserved codes act as single beat
  assign mask = (lenCode == BL_2)    ? COL_BITS'(1) :
                (lenCode == BL_4)    ? COL_BITS'(3) :
                (lenCode == BL_8)    ? COL_BITS'(7) :
                (lenCode == BL_PAGE) ? {COL_BITS{1'b1}} :
                                       '0;                           // [R13] [R14]
  assign fullPage = (lenCode == BL_PAGE);

  // offset inside the block: sequential adds, interleaved xors
  assign seqOff = COL_BITS'(startCol + beatCount) & mask;           // [R18] [R17]
  assign intOff = (startCol ^ beatCount) & mask;                     // [R18]

  // page bursts are sequential only
  assign col = (startCol & ~mask) |
               ((interleave && !fullPage) ? intOff : seqOff);        // [R16] [R14]

  // page bursts never end by themselves
  assign lastBeat = !fullPage && (beatCount == mask);                // [R15]

endmodule : smb_burst_order

// >>> rtl/smb_pkg.sv
package smb_pkg;

  // address and mode word
  localparam int          ADDR_W     = 12;
  localparam int          MODE_W     = 12;
  localparam logic [11:0] MODE_RESET = 12'h000;

  // mode word field positions
  localparam int BL_LSB   = 0;
  localparam int BL_W     = 3;
  localparam int BT_BIT   = 3;
  localparam int CL_LSB   = 4;
  localparam int CL_W     = 3;
  localparam int OPM_LSB  = 7;
  localparam int OPM_W    = 2;
  localparam int WBM_BIT  = 9;
  localparam int RSV_LSB  = 10;

  // burst length codes
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;

  // read latency codes and operating mode
  localparam logic [2:0] CL_2       = 3'h2;
  localparam logic [2:0] CL_3       = 3'h3;
  localparam logic [1:0] OPM_NORMAL = 2'h0;

  // address bit that selects all banks on a precharge
  localparam int AP_BIT = 10;

  // command pin patterns {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] PAT_LOAD_MODE = 3'h0;
  localparam logic [2:0] PAT_REFRESH   = 3'h1;
  localparam logic [2:0] PAT_PRECHARGE = 3'h2;
  localparam logic [2:0] PAT_ACTIVE    = 3'h3;
  localparam logic [2:0] PAT_WRITE     = 3'h4;
  localparam logic [2:0] PAT_READ      = 3'h5;
  localparam logic [2:0] PAT_TERMINATE = 3'h6;
  localparam logic [2:0] PAT_NOP       = 3'h7;

  // timing
  localparam int POWERUP_WAIT_US       = 100;
  localparam int CLK_FREQ_MHZ          = 100;
  localparam int POWERUP_CYCLES        = POWERUP_WAIT_US * CLK_FREQ_MHZ;
  localparam int MODE_LOAD_GAP_CYCLES  = 2;
  localparam int REFRESH_COUNT_INIT    = 2;

  typedef enum logic [3:0] {
    CMD_INHIBIT,
    CMD_NOP,
    CMD_LOAD_MODE,
    CMD_REFRESH,
    CMD_PRECHARGE,
    CMD_ACTIVE,
    CMD_WRITE,
    CMD_READ,
    CMD_TERMINATE
  } smb_cmd_type;

  typedef enum logic [2:0] {
    ST_POWERUP,
    ST_PRECHARGE,
    ST_REFRESH,
    ST_MODE,
    ST_READY
  } smb_init_type;

endpackage : smb_pkg

// >>> rtl/smb_sdram_core.sv
// Summary of operation
// [R1] all command, address and data inputs are sampled on the rising clock edge
// [R2] four banks of 4096 rows by 256 columns, each location a 16-bit word
// [R3] controller opens a row with ACTIVE before any READ or WRITE to it
// [R4] ACTIVE takes bank from the two bank lines and row from twelve address lines
// [R5] READ or WRITE takes the starting column from the low eight address lines
// [R6] controller issues only inhibit or NOP for at least 100 us after power-up
// [R7] after the wait and at least one NOP, controller precharges all banks
// [R8] with banks idle, controller performs two auto refreshes before mode loading
// [R9] mode word is undefined until loaded; load it before any operational command
// [R10] mode word changes only on LOAD MODE and holds until the next one
// [R11] mode word: length 0-2, type 3, latency 4-6, op mode 7-8, write mode 9
// [R12] mode loads only with all banks idle, then wait before the next command
// [R13] burst length sets the maximum locations touched by one READ or WRITE
// [R14] lengths 1, 2, 4, 8 for both types; full page for sequential only
// [R15] full-page burst runs until terminated; used with BURST TERMINATE
// [R16] burst wraps inside an aligned block; low column bits give the start
// [R17] full-page burst wraps to the start of the same page
// [R18] sequential adds offset modulo length; interleaved xors start with a count
// [R19] read latency programmable to two or three clocks
// [R20] read at edge n, latency m: drive from edge n+m-1, valid by n+m
// [R21] controller should never program reserved length or latency codes
// [R22] normal operation only when both operating mode bits are zero
// [R23] write mode bit set makes each write a single location; reads still burst
// [R24] LOAD MODE copies address bit i into mode bit i
`timescale 1ns/1ps
module smb_sdram_core
  import smb_pkg::*;
#(
  parameter int ROW_BITS          = 12,
  parameter int COL_BITS          = 8,
  parameter int DATA_W            = 16,
  parameter int POWERUP_CYCLES_P  = POWERUP_CYCLES
) (
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  input  wire logic              chipSelectN,
  input  wire logic              rowStrobeN,
  input  wire logic              colStrobeN,
  input  wire logic              writeEnableN,
  input  wire logic              bank_select_lo,
  input  wire logic              bank_select_hi,
  input  wire logic [ADDR_W-1:0] addrIn,
  input  wire logic [DATA_W-1:0] dqIn,
  output logic      [DATA_W-1:0] dqOut,
  output logic                   dqOutEnN,
  output logic                   initDone,
  output logic                   protocolFault
);

  localparam int BANKS  = 4;
  localparam int IDX_W  = 2 + ROW_BITS + COL_BITS;
  localparam int DEPTH  = BANKS << (ROW_BITS + COL_BITS);
  localparam int WAIT_W = $clog2(POWERUP_CYCLES_P + 1);

  function automatic smb_cmd_type decodeCmd(input logic csN, input logic [2:0] pat);
    smb_cmd_type c;
    c = CMD_NOP;
    if (csN) begin
      c = CMD_INHIBIT;
    end else begin
      unique case (pat)
        PAT_LOAD_MODE: c = CMD_LOAD_MODE;
        PAT_REFRESH:   c = CMD_REFRESH;
        PAT_PRECHARGE: c = CMD_PRECHARGE;
        PAT_ACTIVE:    c = CMD_ACTIVE;
        PAT_WRITE:     c = CMD_WRITE;
        PAT_READ:      c = CMD_READ;
        PAT_TERMINATE: c = CMD_TERMINATE;
        PAT_NOP:       c = CMD_NOP;
      endcase
    end
    return c;
  endfunction : decodeCmd

  // command decode, sampled on the rising edge only
  smb_cmd_type cmd;
  logic [1:0]  bankSel;
  logic        cmdIdle;
  logic        cmdRwAny;
  assign cmd      = decodeCmd(chipSelectN, {rowStrobeN, colStrobeN, writeEnableN}); // [R1]
  assign bankSel  = {bank_select_hi, bank_select_lo};                              // [R4]
  assign cmdIdle  = (cmd == CMD_NOP) || (cmd == CMD_INHIBIT);
  assign cmdRwAny = (cmd == CMD_READ) || (cmd == CMD_WRITE);

  // mode word and its fields
  logic [MODE_W-1:0] modeWord_q;
  logic              modeLoaded_q;
  logic [2:0]        lenCode;
  logic              interleave;
  logic              latency3;
  logic              normalMode;
  logic              singleWrite;
  assign lenCode     = modeWord_q[BL_LSB +: BL_W];                 // [R11]
  assign interleave  = modeWord_q[BT_BIT];                         // [R11]
  assign latency3    = (modeWord_q[CL_LSB +: CL_W] != CL_2);       // [R19]
  assign normalMode  = (modeWord_q[OPM_LSB +: OPM_W] == OPM_NORMAL); // [R22]
  assign singleWrite = modeWord_q[WBM_BIT];                        // [R23]

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      modeWord_q   <= MODE_RESET;
      modeLoaded_q <= 1'b0;
    end else if (cmd == CMD_LOAD_MODE) begin
      modeWord_q   <= addrIn[MODE_W-1:0];                          // [R10] [R24]
      modeLoaded_q <= 1'b1;                                        // [R9]
    end
  end

  // per-bank open row tracking
  logic [BANKS-1:0]    rowOpen_q;
  logic [ROW_BITS-1:0] openRow_q [BANKS];
  logic [BANKS-1:0]    preHit;

  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    assign preHit[b] = (cmd == CMD_PRECHARGE) && (addrIn[AP_BIT] || bankSel == 2'(b));
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        rowOpen_q[b] <= 1'b0;
        openRow_q[b] <= '0;
      end else if (cmd == CMD_ACTIVE && bankSel == 2'(b)) begin
        rowOpen_q[b] <= 1'b1;
        openRow_q[b] <= addrIn[ROW_BITS-1:0];                      // [R4]
      end else if (preHit[b]) begin
        rowOpen_q[b] <= 1'b0;
      end
    end
  end

  // burst state
  logic                burstActive_q;
  logic                burstWrite_q;
  logic [1:0]          burstBank_q;
  logic [COL_BITS-1:0] burstStart_q;
  logic [COL_BITS-1:0] burstCnt_q;

  logic                cmdRw;
  logic                cmdStop;
  logic                effActive;
  logic                effWrite;
  logic [1:0]          effBank;
  logic [COL_BITS-1:0] effStart;
  logic [COL_BITS-1:0] effCnt;
  logic [2:0]          effLen;
  logic [COL_BITS-1:0] effCol;
  logic                lastBeat;

  // accesses only to an open row, with a loaded normal mode word
  assign cmdRw    = cmdRwAny && modeLoaded_q && normalMode && rowOpen_q[bankSel]; // [R3] [R9] [R22]
  assign cmdStop  = (cmd == CMD_TERMINATE) || preHit[burstBank_q] || cmdRwAny;    // [R15]
  assign effActive = cmdRw || (burstActive_q && !cmdStop);
  assign effWrite  = cmdRw ? (cmd == CMD_WRITE) : burstWrite_q;
  assign effBank   = cmdRw ? bankSel : burstBank_q;
  assign effStart  = cmdRw ? addrIn[COL_BITS-1:0] : burstStart_q;                 // [R5]
  assign effCnt    = cmdRw ? '0 : burstCnt_q;
  assign effLen    = (effWrite && singleWrite) ? BL_1 : lenCode;                   // [R23]

  smb_burst_order #(
    .COL_BITS (COL_BITS)
  ) u_order (
    .startCol   (effStart),
    .beatCount  (effCnt),
    .lenCode    (effLen),
    .interleave (interleave),
    .col        (effCol),
    .lastBeat   (lastBeat)
  );

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      burstActive_q <= 1'b0;
      burstWrite_q  <= 1'b0;
      burstBank_q   <= 2'h0;
      burstStart_q  <= '0;
      burstCnt_q    <= '0;
    end else begin
      burstActive_q <= effActive && !lastBeat;                     // [R13]
      burstWrite_q  <= effWrite;
      burstBank_q   <= effBank;
      burstStart_q  <= effStart;
      burstCnt_q    <= COL_BITS'(effCnt + 1'b1);                   // [R17]
    end
  end

  // storage: bank, row, column index
  logic [DATA_W-1:0] mem [DEPTH];
  logic [IDX_W-1:0]  memIdx;
  logic [DATA_W-1:0] memRd;
  assign memIdx = {effBank, openRow_q[effBank], effCol};           // [R2]
  assign memRd  = mem[memIdx];

  always_ff @(posedge clk_sys) begin
    if (effActive && effWrite) begin
      mem[memIdx] <= dqIn;                                         // [R1]
    end
  end

  // read latency pipeline
  logic [DATA_W-1:0] rdPipe1_q;
  logic [DATA_W-1:0] rdPipe2_q;
  logic              rdVal1_q;
  logic              rdVal2_q;
  logic [DATA_W-1:0] dqOut_q;
  logic              dqOutEnN_q;
  logic [DATA_W-1:0] dqOut_d;
  logic              dqOutEnN_d;
  assign dqOut_d    = latency3 ? rdPipe2_q : rdPipe1_q;            // [R19]
  assign dqOutEnN_d = !(latency3 ? rdVal2_q : rdVal1_q);           // [R20]

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdPipe1_q  <= '0;
      rdPipe2_q  <= '0;
      rdVal1_q   <= 1'b0;
      rdVal2_q   <= 1'b0;
      dqOut_q    <= '0;
      dqOutEnN_q <= 1'b1;
    end else begin
      rdPipe1_q  <= memRd;
      rdVal1_q   <= effActive && !effWrite;
      rdPipe2_q  <= rdPipe1_q;
      rdVal2_q   <= rdVal1_q;
      dqOut_q    <= dqOut_d;                                       // [R20]
      dqOutEnN_q <= dqOutEnN_d;
    end
  end

  assign dqOut    = dqOut_q;
  assign dqOutEnN = dqOutEnN_q;

  // power-up sequence tracker and command-order checks
  smb_init_type      initState_q;
  smb_init_type      initState_d;
  logic [WAIT_W-1:0] waitCnt_q;
  logic [1:0]        refCnt_q;
  logic [1:0]        mrdCnt_q;
  logic              initDone_q;
  logic              fault_q;
  logic              waitDone;
  logic              seqBad;
  logic              modeBad;
  logic              gapBad;

  assign waitDone = (waitCnt_q == WAIT_W'(POWERUP_CYCLES_P));
  assign modeBad  = (cmd == CMD_LOAD_MODE) && (rowOpen_q != '0);        // [R12]
  assign gapBad   = (mrdCnt_q != 2'h0) && !cmdIdle;                      // [R12]

  always_comb begin
    initState_d = initState_q;
    seqBad      = 1'b0;
    unique case (initState_q)
      ST_POWERUP: begin
        seqBad = !cmdIdle;                                               // [R6]
        if (waitDone) begin
          initState_d = ST_PRECHARGE;
        end
      end
      ST_PRECHARGE: begin
        if (cmd == CMD_PRECHARGE && addrIn[AP_BIT]) begin
          initState_d = ST_REFRESH;                                      // [R7]
        end else begin
          seqBad = !cmdIdle;
        end
      end
      ST_REFRESH: begin
        if (cmd == CMD_REFRESH && refCnt_q == 2'h1) begin
          initState_d = ST_MODE;                                         // [R8]
        end else begin
          seqBad = !cmdIdle && cmd != CMD_REFRESH;
        end
      end
      ST_MODE: begin
        if (cmd == CMD_LOAD_MODE) begin
          initState_d = ST_READY;                                        // [R9]
        end else begin
          seqBad = !cmdIdle;
        end
      end
      ST_READY: begin
        initState_d = ST_READY;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      initState_q <= ST_POWERUP;
      waitCnt_q   <= '0;
      refCnt_q    <= 2'(REFRESH_COUNT_INIT);
      mrdCnt_q    <= 2'h0;
      initDone_q  <= 1'b0;
      fault_q     <= 1'b0;
    end else begin
      initState_q <= initState_d;
      if (initState_q == ST_POWERUP && !waitDone) begin
        waitCnt_q <= WAIT_W'(waitCnt_q + 1'b1);                          // [R6]
      end
      if (initState_q == ST_REFRESH && cmd == CMD_REFRESH) begin
        refCnt_q <= 2'(refCnt_q - 1'b1);                                 // [R8]
      end
      if (cmd == CMD_LOAD_MODE) begin
        mrdCnt_q <= 2'(MODE_LOAD_GAP_CYCLES - 1);                        // [R12]
      end else if (mrdCnt_q != 2'h0) begin
        mrdCnt_q <= 2'(mrdCnt_q - 1'b1);
      end
      initDone_q <= (initState_d == ST_READY);
      if (seqBad || modeBad || gapBad) begin
        fault_q <= 1'b1;
      end
    end
  end

  assign initDone      = initDone_q;
  assign protocolFault = fault_q;

endmodule : smb_sdram_core

// >>> sim/smb_ctrl_model.sv
`timescale 1ns/1ps
module smb_ctrl_model
  import smb_pkg::*;
(
  input  wire logic clk_sys,
  output logic      chipSelectN,
  output logic      rowStrobeN,
  output logic      colStrobeN,
  output logic      writeEnableN,
  output logic [1:0]  bankSel,
  output logic [11:0] cmdAddr,
  output logic [15:0] cmdData
);
  initial begin
    {chipSelectN, rowStrobeN, colStrobeN, writeEnableN} = 4'hf;
    bankSel = 2'h0;
    cmdAddr = 12'h000;
    cmdData = 16'h0000;
  end

  // drives change at the falling edge, sampled at the rising one
  task automatic drive(input logic [2:0] p, input logic [1:0] b, input logic [11:0] a,
                       input logic [15:0] d);
    @(negedge clk_sys);
    chipSelectN = 1'b0;
    {rowStrobeN, colStrobeN, writeEnableN} = p;
    bankSel = b;
    cmdAddr = a;
    cmdData = d;
  endtask : drive

  // released data lines show a moving pattern
  task automatic idle();
    drive(PAT_NOP, 2'h0, 12'h000, ~cmdData);
  endtask : idle

  task automatic initSeq(input int waitCycles, input logic [11:0] mode);
    repeat (waitCycles + 2) idle();
    drive(PAT_PRECHARGE, 2'h0, 12'h400, ~cmdData);
    idle();
    repeat (2) begin
      drive(PAT_REFRESH, 2'h0, 12'h000, ~cmdData);
      idle();
    end
    drive(PAT_LOAD_MODE, 2'h0, mode, ~cmdData);
    repeat (2) idle();
  endtask : initSeq

  // callers pass only supported length and latency codes
  task automatic loadMode(input logic [11:0] mode);
    drive(PAT_PRECHARGE, 2'h0, 12'h400, ~cmdData);
    repeat (2) idle();
    drive(PAT_LOAD_MODE, 2'h0, mode, ~cmdData);
    repeat (2) idle();
  endtask : loadMode
endmodule : smb_ctrl_model

// >>> sim/smb_sdram_core_bench.sv
`timescale 1ns/1ps
module smb_sdram_core_bench
  import smb_pkg::*;
;
  localparam int PWR = 20;
  logic        clk_sys = 1'b0;
  logic        arst_n  = 1'b0;
  logic        chipSelectN, rowStrobeN, colStrobeN, writeEnableN;
  logic [1:0]  bankSel;
  logic [11:0] addrIn;
  logic [15:0] dqIn, dqOut;
  logic        dqOutEnN, initDone, protocolFault;
  int          fail_count = 0;
  int          compares   = 0;
  int          cycles     = 0;

  always #5 clk_sys = ~clk_sys;

  smb_ctrl_model u_ctrl (.clk_sys(clk_sys), .chipSelectN(chipSelectN), .rowStrobeN(rowStrobeN),
    .colStrobeN(colStrobeN), .writeEnableN(writeEnableN), .bankSel(bankSel),
    .cmdAddr(addrIn), .cmdData(dqIn));

  smb_sdram_core #(.POWERUP_CYCLES_P(PWR)) u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .chipSelectN(chipSelectN), .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
    .writeEnableN(writeEnableN), .bank_select_lo(bankSel[0]), .bank_select_hi(bankSel[1]),
    .addrIn(addrIn), .dqIn(dqIn), .dqOut(dqOut), .dqOutEnN(dqOutEnN), .initDone(initDone),
    .protocolFault(protocolFault));

  function automatic logic [11:0] mw(logic w, logic [2:0] cl, logic bt, logic [2:0] bl);
    return {2'h0, w, 2'h0, cl, bt, bl};
  endfunction : mw

  function automatic logic [7:0] colAt(logic [7:0] s, int k, logic [2:0] bl, logic il);
    logic [7:0] m;
    m = (bl == BL_PAGE) ? 8'hff : 8'((1 << bl) - 1);
    return (s & ~m) | ((il ? (s ^ 8'(k)) : (s + 8'(k))) & m);
  endfunction : colAt

  task automatic chkData(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chkData

  task automatic chkFlag(string what, logic exp, logic got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chkFlag

  task automatic doReset();
    arst_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'b1;
  endtask : doReset

  task automatic act();
    u_ctrl.drive(PAT_ACTIVE, 2'h1, 12'h9a5, ~dqIn);
    u_ctrl.idle();
  endtask : act

  task automatic wrBurst(logic [7:0] s, int n, logic [2:0] bl, logic il, logic [7:0] g);
    u_ctrl.drive(PAT_WRITE, 2'h1, {4'h0, s}, {g, colAt(s, 0, bl, il)});
    for (int k = 1; k < n; k++) u_ctrl.drive(PAT_NOP, 2'h1, 12'h000, {g, colAt(s, k, bl, il)});
  endtask : wrBurst

  task automatic rdBurst(logic [7:0] s, int n, int lat, logic [2:0] bl, logic il,
                         logic [7:0] g0, logic [7:0] g);
    u_ctrl.drive(PAT_READ, 2'h1, {4'h0, s}, ~dqIn);
    repeat (lat) u_ctrl.idle();
    for (int k = 0; k < n; k++) begin
      chkData("read beat", {(k == 0) ? g0 : g, colAt(s, k, bl, il)}, dqOut);
      chkFlag("drive enable", 1'b0, dqOutEnN);
      u_ctrl.idle();
    end
    if (bl != BL_PAGE) chkFlag("drive end", 1'b1, dqOutEnN);
  endtask : rdBurst

  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      results();
    end
  end

  initial begin
    doReset();
    chkFlag("reset enable", 1'b1, dqOutEnN);
    u_ctrl.initSeq(PWR, mw(1'b0, CL_3, 1'b1, BL_8));
    chkFlag("init done", 1'b1, initDone);
    chkFlag("no fault", 1'b0, protocolFault);
    $display("test init done");
    act();
    wrBurst(8'h13, 8, BL_8, 1'b1, 8'h5a);
    u_ctrl.idle();
    rdBurst(8'h15, 8, 3, BL_8, 1'b1, 8'h5a, 8'h5a);
    u_ctrl.drive(PAT_READ, 2'h2, 12'h015, ~dqIn);
    repeat (5) begin
      u_ctrl.idle();
      chkFlag("closed bank", 1'b1, dqOutEnN);
    end
    $display("test interleave done");
    u_ctrl.loadMode(mw(1'b0, CL_2, 1'b0, BL_2));
    act();
    rdBurst(8'h17, 2, 2, BL_2, 1'b0, 8'h5a, 8'h5a);
    $display("test short done");
    u_ctrl.loadMode(mw(1'b0, CL_3, 1'b0, BL_PAGE));
    act();
    wrBurst(8'hfe, 4, BL_PAGE, 1'b0, 8'h77);
    u_ctrl.drive(PAT_TERMINATE, 2'h1, 12'h000, ~dqIn);
    u_ctrl.idle();
    rdBurst(8'hfe, 4, 3, BL_PAGE, 1'b0, 8'h77, 8'h77);
    $display("test page done");
    u_ctrl.loadMode(mw(1'b1, CL_2, 1'b0, BL_4));
    act();
    wrBurst(8'h10, 4, BL_4, 1'b0, 8'hc3);
    u_ctrl.idle();
    rdBurst(8'h10, 4, 2, BL_4, 1'b0, 8'hc3, 8'h5a);
    $display("test single write done");
    u_ctrl.loadMode(mw(1'b0, CL_2, 1'b0, BL_4) | 12'h080);
    act();
    u_ctrl.drive(PAT_READ, 2'h1, 12'h010, ~dqIn);
    repeat (4) begin
      u_ctrl.idle();
      chkFlag("test mode read", 1'b1, dqOutEnN);
    end
    chkFlag("no fault", 1'b0, protocolFault);
    u_ctrl.drive(PAT_LOAD_MODE, 2'h0, 12'h032, ~dqIn);
    u_ctrl.idle();
    chkFlag("open row load", 1'b1, protocolFault);
    $display("test mode guard done");
    doReset();
    chkFlag("reset ready", 1'b0, initDone);
    chkFlag("reset fault", 1'b0, protocolFault);
    u_ctrl.drive(PAT_READ, 2'h1, 12'h000, ~dqIn);
    u_ctrl.idle();
    chkFlag("early read", 1'b1, protocolFault);
    $display("test reset done");
    results();
  end
endmodule : smb_sdram_core_bench

// >>> sim/smb_sdram_core_checker.sv
`timescale 1ns/1ps
module smb_sdram_core_checker
  import smb_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              arst_n,
  input wire logic              chipSelectN,
  input wire logic              rowStrobeN,
  input wire logic              colStrobeN,
  input wire logic              writeEnableN,
  input wire logic [ADDR_W-1:0] addrIn,
  input wire logic              dqOutEnN,
  input wire logic              initDone,
  input wire logic              protocolFault
);
  logic [2:0]        pat;
  logic              isRead;
  logic              isLoad;
  logic              isOp;
  logic              isLat2;
  logic [7:0]        limit;
  logic [MODE_W-1:0] modeWord_q;
  logic [7:0]        sinceRead_q;

  assign pat    = {rowStrobeN, colStrobeN, writeEnableN};
  assign isOp   = !chipSelectN && pat != PAT_NOP;
  assign isRead = !chipSelectN && pat == PAT_READ;
  assign isLoad = !chipSelectN && pat == PAT_LOAD_MODE;
  assign isLat2 = modeWord_q[6:4] == CL_2;
  assign limit  = (isLat2 ? 8'h02 : 8'h03) + (8'h01 << modeWord_q[1:0]) - 8'h02;

  // mirror of the mode word and cycles since the last read
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      modeWord_q  <= MODE_RESET;
      sinceRead_q <= 8'hff;
    end else begin
      if (isLoad) modeWord_q <= addrIn;
      if (isRead) sinceRead_q <= 8'h00;
      else if (sinceRead_q != 8'hff) sinceRead_q <= sinceRead_q + 8'h01;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  fault_sticky_a: assert property (protocolFault |=> protocolFault)
    else $error("fault flag dropped");
  fault_cause_a: assert property ($rose(protocolFault) |-> $past(isOp))
    else $error("fault without a command");
  rd_latency_a: assert property ($fell(dqOutEnN) |->
    (isLat2 ? $past(isRead, 2) : $past(isRead, 3))) else $error("read latency wrong");
  burst_bound_a: assert property ((!dqOutEnN && !modeWord_q[2]) |-> sinceRead_q <= limit)
    else $error("burst too long");
  init_rise_a: assert property ($rose(initDone) |-> $past(isLoad))
    else $error("ready without mode load");
  init_hold_a: assert property (initDone |=> initDone)
    else $error("ready flag dropped");
  idle_before_a: assert property (!initDone |-> dqOutEnN)
    else $error("data driven before mode load");
  early_read_a: assert property ((isRead && !initDone) |=> protocolFault)
    else $error("early read not flagged");

  cover property ($rose(initDone));
  cover property ($fell(dqOutEnN) && isLat2);
  cover property ($rose(protocolFault));
endmodule : smb_sdram_core_checker

bind smb_sdram_core smb_sdram_core_checker u_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .chipSelectN(chipSelectN),
  .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .writeEnableN(writeEnableN),
  .addrIn(addrIn), .dqOutEnN(dqOutEnN), .initDone(initDone), .protocolFault(protocolFault)
);
